// ---- common/nibble_swap_xor_pkg.sv ----
// constants and types for the nibble swap / xor / direction-load executor
package nibble_swap_xor_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSN_W = 12;
  localparam int unsigned FADDR_W = 5;
  // opcode match patterns and positions
  localparam logic [5:0] SWAP_PAT = 6'h0e;  // 0011 10 in bits 11:6
  localparam logic [5:0] XORF_PAT = 6'h06;  // 0001 10 in bits 11:6
  localparam logic [3:0] XORL_PAT = 4'hf;   // 1111 in bits 11:8
  localparam logic [8:0] DIRL_PAT = 9'h000; // 0000 0000 0 in bits 11:3
  localparam logic [2:0] DIR_PORT_SEL = 3'h6;
  localparam int unsigned DEST_BIT = 5;
  // values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic ZERO_RST = 1'h0;
  localparam int unsigned EXEC_CYCLES = 1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SWAP,
    OP_DIR,
    OP_XORL,
    OP_XORF
  } exec_op_t;
endpackage

// ---- logic/nibble_swap_xor_load_direction_op_exec.sv ----
// decode and one-cycle execute of nibble swap, direction load and xor ops
`timescale 1ns/100ps
`default_nettype none
module nibble_swap_xor_load_direction_op_exec (
  input wire logic sys_clk, // 125 MHz core clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic insn_valid, // instruction word valid this cycle
  input wire logic [11:0] insn, // 12-bit instruction word
  input wire logic [7:0] file_rdata, // contents of file register at file_addr
  output logic [4:0] file_addr, // file register address, from insn
  output logic file_we, // file register write strobe
  output logic [7:0] file_wdata, // file register write data
  output logic [7:0] acc, // working accumulator
  output logic [7:0] port_dir, // port direction register
  output logic zero_flag, // zero status flag
  output logic insn_hit // instruction decoded by this block
);
  // one record of all state; the write data rides with its strobe
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] dir;
    logic zero;
    logic fwe;
    logic [7:0] fwdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;
  nibble_swap_xor_pkg::exec_op_t op;
  logic dest_file;
  logic [7:0] result;

  // address is combinational so the file read lands in the instruction's own cycle
  assign file_addr = insn[nibble_swap_xor_pkg::FADDR_W-1:0];
  assign dest_file = insn[nibble_swap_xor_pkg::DEST_BIT];

  // the four patterns are disjoint, so the if order carries no priority
  always_comb begin
    op = nibble_swap_xor_pkg::OP_NONE;
    if (insn_valid) begin
      if (insn[11:6] == nibble_swap_xor_pkg::SWAP_PAT) begin
        op = nibble_swap_xor_pkg::OP_SWAP;
      end else if (insn[11:6] == nibble_swap_xor_pkg::XORF_PAT) begin
        op = nibble_swap_xor_pkg::OP_XORF;
      end else if (insn[11:8] == nibble_swap_xor_pkg::XORL_PAT) begin
        op = nibble_swap_xor_pkg::OP_XORL;
      end else if (insn[11:3] == nibble_swap_xor_pkg::DIRL_PAT &&
                   insn[2:0] == nibble_swap_xor_pkg::DIR_PORT_SEL) begin
        // other selectors name a port this device lacks, so they are ignored
        op = nibble_swap_xor_pkg::OP_DIR;
      end
    end
  end

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.fwe = 1'b0;
    // fwdata keeps its last value; only fwe qualifies it
    result = 8'h00;
    unique case (op)
      nibble_swap_xor_pkg::OP_SWAP: begin
        result = {file_rdata[3:0], file_rdata[7:4]};
      end
      nibble_swap_xor_pkg::OP_XORF: begin
        result = cur_ff.acc ^ file_rdata;
      end
      nibble_swap_xor_pkg::OP_XORL: begin
        result = cur_ff.acc ^ insn[7:0];
      end
      nibble_swap_xor_pkg::OP_DIR: result = cur_ff.acc;
      nibble_swap_xor_pkg::OP_NONE: result = 8'h00;
    endcase
    unique case (op)
      nibble_swap_xor_pkg::OP_SWAP, nibble_swap_xor_pkg::OP_XORF: begin
        if (dest_file) begin
          nxt_ff.fwe = 1'b1;
          nxt_ff.fwdata = result;
        end else begin
          nxt_ff.acc = result;
        end
      end
      nibble_swap_xor_pkg::OP_XORL: begin
        nxt_ff.acc = result;
      end
      nibble_swap_xor_pkg::OP_DIR: begin
        nxt_ff.dir = result;
      end
      nibble_swap_xor_pkg::OP_NONE: nxt_ff.fwe = 1'b0;
    endcase
    // swap and direction load skip this, so the flag is kept
    // zero flag from xor
    if (op == nibble_swap_xor_pkg::OP_XORF || op == nibble_swap_xor_pkg::OP_XORL) begin
      nxt_ff.zero = (result == 8'h00);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff.acc <= nibble_swap_xor_pkg::ACC_RST;
      cur_ff.dir <= nibble_swap_xor_pkg::DIR_RST;
      cur_ff.zero <= nibble_swap_xor_pkg::ZERO_RST;
      cur_ff.fwe <= 1'b0;
      cur_ff.fwdata <= 8'h00;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign acc = cur_ff.acc;
  assign port_dir = cur_ff.dir;
  assign zero_flag = cur_ff.zero;
  // write is registered one cycle late; the caller holds the address for it
  assign file_we = cur_ff.fwe;
  assign file_wdata = cur_ff.fwdata;
  assign insn_hit = (op != nibble_swap_xor_pkg::OP_NONE);

  // assertions, all in the core clock domain
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // each result is judged one edge after the edge that took the instruction

  swap_to_acc_a: assert property (
    (insn_valid && insn[11:6] == 6'h0e && !insn[5])
      |=> acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && !file_we)
    else $error("nibble swap into accumulator wrong");
  swap_flags_kept_a: assert property (
    (op == nibble_swap_xor_pkg::OP_SWAP) |=> $stable(zero_flag))
    else $error("nibble swap changed zero flag");
  swap_to_file_a: assert property (
    (op == nibble_swap_xor_pkg::OP_SWAP && dest_file)
      |=> file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
          && $stable(acc))
    else $error("nibble swap to file wrong");

  dir_load_a: assert property (
    (insn_valid && insn == 12'h006) |=> port_dir == $past(acc) && $stable(zero_flag))
    else $error("direction load wrong");

  xorl_value_a: assert property (
    (insn_valid && insn[11:8] == 4'hf) |=> acc == ($past(acc) ^ $past(insn[7:0])))
    else $error("literal xor result wrong");
  xorl_no_file_a: assert property (
    (op == nibble_swap_xor_pkg::OP_XORL) |=> !file_we && $stable(port_dir))
    else $error("literal xor touched file");

  xorf_dest_a: assert property (
    (op == nibble_swap_xor_pkg::OP_XORF && dest_file)
      |=> file_we && file_wdata == ($past(acc) ^ $past(file_rdata)) && $stable(acc))
    else $error("register xor to file wrong");
  xorf_acc_a: assert property (
    (op == nibble_swap_xor_pkg::OP_XORF && !dest_file)
      |=> !file_we && acc == ($past(acc) ^ $past(file_rdata)))
    else $error("register xor to accumulator wrong");
  xorl_zero_a: assert property (
    (op == nibble_swap_xor_pkg::OP_XORL) |=> zero_flag == (acc == 8'h00))
    else $error("zero flag wrong after literal xor");
  xorf_zero_acc_a: assert property (
    (op == nibble_swap_xor_pkg::OP_XORF && !dest_file)
      |=> zero_flag == (acc == 8'h00))
    else $error("zero flag wrong after register xor to accumulator");
  xorf_zero_file_a: assert property (
    (op == nibble_swap_xor_pkg::OP_XORF && dest_file)
      |=> zero_flag == (file_wdata == 8'h00))
    else $error("zero flag wrong after register xor to file");
  zero_only_xor_a: assert property (
    !$stable(zero_flag) |-> $past(insn_valid)
      && ($past(insn[11:8]) == 4'hf || $past(insn[11:6]) == 6'h06))
    else $error("zero flag changed without an xor");

  // refused words and idle cycles must leave every piece of state alone
  dir_other_sel_a: assert property (
    (insn_valid && insn[11:3] == 9'h000 && insn[2:0] != 3'h6)
      |=> $stable(port_dir) && $stable(acc) && !file_we)
    else $error("unsupported direction selector acted");
  idle_hold_a: assert property (
    (!insn_hit) |=> !file_we && $stable(acc) && $stable(port_dir) && $stable(zero_flag))
    else $error("state changed without a decoded instruction");
  hit_on_match_a: assert property (
    (insn_valid && (insn[11:8] == 4'hf || insn[11:6] == 6'h0e || insn[11:6] == 6'h06
      || insn == 12'h006)) == insn_hit)
    else $error("instruction hit does not match opcode");
  addr_from_insn_a: assert property (
    file_addr == insn[4:0])
    else $error("file address not taken from instruction");

  // side effects confined to the instruction's own target
  dir_only_a: assert property (
    (op == nibble_swap_xor_pkg::OP_DIR) |=> !file_we && $stable(acc))
    else $error("direction load touched accumulator or file");
  dir_source_a: assert property (
    !$stable(port_dir) |-> $past(insn_valid) && $past(insn) == 12'h006)
    else $error("direction register changed without a load");
  swap_dir_kept_a: assert property (
    (op == nibble_swap_xor_pkg::OP_SWAP) |=> $stable(port_dir))
    else $error("nibble swap changed direction register");
  xorf_dir_kept_a: assert property (
    (op == nibble_swap_xor_pkg::OP_XORF) |=> $stable(port_dir))
    else $error("register xor changed direction register");
  file_we_source_a: assert property (
    file_we |-> $past(insn_valid) && $past(insn[5])
      && ($past(insn[11:6]) == 6'h0e || $past(insn[11:6]) == 6'h06))
    else $error("file write without a file-destined instruction");

  swap_seen_c: cover property (
    op == nibble_swap_xor_pkg::OP_SWAP && dest_file);
  xorf_file_c: cover property (
    op == nibble_swap_xor_pkg::OP_XORF && dest_file);
  back_to_back_c: cover property (
    op == nibble_swap_xor_pkg::OP_XORL ##1 op == nibble_swap_xor_pkg::OP_XORF);
  dir_seen_c: cover property (op == nibble_swap_xor_pkg::OP_DIR);
  xor_zero_c: cover property (op == nibble_swap_xor_pkg::OP_XORL ##1 zero_flag);
endmodule // nibble_swap_xor_load_direction_op_exec
`default_nettype wire

// ---- tb/nibble_swap_xor_load_direction_op_exec_bench.sv ----
// self-checking bench for the nibble swap / xor / direction-load executor
`timescale 1ns/100ps
`default_nettype none
module nibble_swap_xor_load_direction_op_exec_bench;
  logic sys_clk, arst_n, insn_valid, file_we, insn_hit, zero_flag;
  logic [11:0] insn;
  logic [7:0] file_rdata, file_wdata, acc, port_dir;
  logic [4:0] file_addr;
  int err_total = 0;
  int num_checks = 0;
  nibble_swap_xor_load_direction_op_exec dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .insn_valid(insn_valid), .insn(insn), .file_rdata(file_rdata), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .acc(acc), .port_dir(port_dir),
    .zero_flag(zero_flag), .insn_hit(insn_hit));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(input string what, input logic e, input logic g);
    chk8(what, {7'h00, e}, {7'h00, g});
  endtask
  // one instruction for one cycle, then outputs judged the cycle after
  task automatic step(input logic [11:0] i, input logic [7:0] rd, input logic hit,
      input logic [7:0] ea, input logic ez, input logic ew, input logic [7:0] ewd);
    @(negedge sys_clk);
    insn_valid = 1'b1;
    insn = i;
    file_rdata = rd;
    #1;
    chk1("insn_hit", hit, insn_hit);
    chk8("file_addr", {3'h0, i[4:0]}, {3'h0, file_addr});
    @(negedge sys_clk);
    insn_valid = 1'b0;
    file_rdata = ~rd;
    chk8("acc", ea, acc);
    chk1("zero_flag", ez, zero_flag);
    chk1("file_we", ew, file_we);
    if (ew === 1'b1) chk8("file_wdata", ewd, file_wdata);
  endtask
  task automatic t_xor_literal;
    step(12'hfb5, 8'h00, 1'b1, 8'hb5, 1'b0, 1'b0, 8'h00);
    step(12'hfb5, 8'hb5, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00);
  endtask
  task automatic t_swap;
    // flag stays set across both swaps
    step(12'h385, 8'ha5, 1'b1, 8'h5a, 1'b1, 1'b0, 8'h00);
    step(12'h3a3, 8'hc3, 1'b1, 8'h5a, 1'b1, 1'b1, 8'h3c);
  endtask
  task automatic t_dir_load;
    chk8("port_dir", nibble_swap_xor_pkg::DIR_RST, port_dir);
    step(12'h007, 8'h00, 1'b0, 8'h5a, 1'b1, 1'b0, 8'h00);
    chk8("port_dir", 8'hff, port_dir);
    step(12'h006, 8'h00, 1'b1, 8'h5a, 1'b1, 1'b0, 8'h00);
    chk8("port_dir", 8'h5a, port_dir);
  endtask
  task automatic t_xor_register;
    step(12'hfef, 8'h00, 1'b1, 8'hb5, 1'b0, 1'b0, 8'h00);
    step(12'h1a5, 8'haf, 1'b1, 8'hb5, 1'b0, 1'b1, 8'h1a);
    step(12'h185, 8'hb5, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00);
    step(12'h1a0, 8'h00, 1'b1, 8'h00, 1'b1, 1'b1, 8'h00);
  endtask
  // mid-run reset, then two instructions back to back using the updated acc
  task automatic t_reset;
    @(negedge sys_clk);
    arst_n = 1'b0;
    #1;
    chk8("acc", nibble_swap_xor_pkg::ACC_RST, acc);
    chk8("port_dir", nibble_swap_xor_pkg::DIR_RST, port_dir);
    chk1("zero_flag", nibble_swap_xor_pkg::ZERO_RST, zero_flag);
    chk1("file_we", 1'b0, file_we);
    @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    insn_valid = 1'b1;
    insn = 12'hf5a;
    @(negedge sys_clk);
    chk8("acc", 8'h5a, acc);
    chk1("zero_flag", 1'b0, zero_flag);
    insn = 12'h182;
    file_rdata = 8'h5a;
    @(negedge sys_clk);
    insn_valid = 1'b0;
    chk8("acc", 8'h00, acc);
    chk1("zero_flag", 1'b1, zero_flag);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // about ten steps of two cycles each; generous margin
  initial begin
    #(8 * 400);
    err_total++;
    complete_run();
  end
  initial begin
    arst_n = 1'b0;
    insn_valid = 1'b0;
    insn = 12'h000;
    file_rdata = 8'h00;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    t_xor_literal();
    t_swap();
    t_dir_load();
    t_xor_register();
    t_reset();
    complete_run();
  end
endmodule // nibble_swap_xor_load_direction_op_exec_bench
`default_nettype wire
